// file: dv/card_identity_asserts.sv
`timescale 1ns/1ps
module card_identity_asserts (
  // clock and reset
  input wire       clk,
  input wire       resetn,
  // read port
  input wire       rd_strobe,
  input wire [7:0] rd_addr,
  input wire [7:0] rd_data,
  input wire       rd_valid,
  // page and interrupts
  input wire       page_wr,
  input wire [3:0] page_wdata,
  input wire [3:0] page,
  input wire       card_normal_irq_n,
  input wire       card_fast_irq_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_low;
    rd_strobe && rd_addr == 8'h00 && page == 4'h0;
  endsequence
  a_read_answer: assert property (rd_strobe |=> rd_valid)
    else $error("read not answered");
  a_present_low: assert property (s_low |=> !rd_data[1])
    else $error("presence bit high");
  a_normal_status: assert property (s_low |=> rd_data[0] == !$past(card_normal_irq_n))
    else $error("normal status wrong");
  a_fast_status: assert property (s_low |=> rd_data[2] == !$past(card_fast_irq_n))
    else $error("fast status wrong");
  a_id_upper: assert property (s_low |=> rd_data[7:3] == 5'h00)
    else $error("id or conform bits set");
  a_reserved_zero: assert property (rd_strobe && rd_addr == 8'h08 |=> rd_data == 8'h00)
    else $error("reserved byte not zero");
  a_flags_upper: assert property (rd_strobe && rd_addr == 8'h04 |=> rd_data[7:4] == 4'h0)
    else $error("flags upper bits set");
  a_page_hold: assert property (!page_wr |=> $stable(page))
    else $error("page moved");
  a_page_write: assert property (page_wr |=> page == $past(page_wdata))
    else $error("page not written");
endmodule

bind card_identity card_identity_asserts card_identity_asserts_inst (
  .clk(clk), .resetn(resetn), .rd_strobe(rd_strobe), .rd_addr(rd_addr), .rd_data(rd_data),
  .rd_valid(rd_valid), .page_wr(page_wr), .page_wdata(page_wdata), .page(page),
  .card_normal_irq_n(card_normal_irq_n), .card_fast_irq_n(card_fast_irq_n));

// file: dv/host_bus_pullup.sv
`timescale 1ns/1ps
module host_bus_pullup (
  // card answer
  input  wire       rd_valid,
  input  wire [7:0] rd_data,
  // host data line
  output wire       bus_data_line_one
);
  // empty slot floats high, so the host sees no card
  assign bus_data_line_one = rd_valid ? rd_data[1] : 1'b1;
endmodule

// file: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  reg         clk = 1'b0;
  reg         resetn = 1'b0;
  reg         rd_strobe = 1'b0;
  reg  [7:0]  rd_addr = 8'h00;
  reg         page_wr = 1'b0;
  reg  [3:0]  page_wdata = 4'h0;
  reg         card_normal_irq_n = 1'b1;
  reg         card_fast_irq_n = 1'b1;
  wire [7:0]  rd_data;
  wire        rd_valid;
  wire [3:0]  page;
  wire        bus_data_line_one;
  integer     n_mismatch = 0;
  integer     checks = 0;
  integer     i;
  reg  [63:0] ext = 64'h9A_56_78_12_34_00_01_00;
  always #5 clk = ~clk;
  card_identity #(.PRODUCT_TYPE(16'h1234), .MAKER_CODE(16'h5678), .COUNTRY(8'h9A))
    card_identity_inst (.clk(clk), .resetn(resetn), .rd_strobe(rd_strobe), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_valid(rd_valid), .page_wr(page_wr), .page_wdata(page_wdata),
    .page(page), .card_normal_irq_n(card_normal_irq_n), .card_fast_irq_n(card_fast_irq_n));
  host_bus_pullup host_bus_pullup_inst (.rd_valid(rd_valid), .rd_data(rd_data),
    .bus_data_line_one(bus_data_line_one));
  task final_report; begin
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  end endtask
  task chk(input [63:0] what, input [7:0] seen, input [7:0] exp); begin
    checks = checks + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected %0s expected %h seen %h", what, exp, seen);
    end
  end endtask
  task rd(input [7:0] a, input [7:0] e); integer k; begin
    rd_strobe = 1'b1;
    rd_addr = a;
    @(negedge clk);
    rd_strobe = 1'b0;
    for (k = 0; k < 4 && rd_valid !== 1'b1; k = k + 1) @(negedge clk);
    if (k == 4) begin n_mismatch = n_mismatch + 1; final_report; end
    chk("rd_data", rd_data, e);
    chk("line_one", {7'h00, bus_data_line_one}, {7'h00, e[1]});
    @(negedge clk);
  end endtask
  task pg(input [3:0] p); begin
    page_wr = 1'b1;
    page_wdata = p;
    @(negedge clk);
    page_wr = 1'b0;
    chk("page", {4'h0, page}, {4'h0, p});
    @(negedge clk);
  end endtask
  initial begin
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    chk("page", {4'h0, page}, 8'h00);
    for (i = 0; i < 8; i = i + 1) rd({i[5:0], 2'b00}, ext[i * 8 +: 8]);
    chk("line_one", {7'h00, bus_data_line_one}, 8'h01);
    card_normal_irq_n = 1'b0;
    rd(8'h00, 8'h01);
    card_fast_irq_n = 1'b0;
    rd(8'h00, 8'h05);
    card_normal_irq_n = 1'b1;
    rd(8'h00, 8'h04);
    rd(8'h20, 8'h00);
    rd(8'h24, 8'h01);
    rd(8'h28, 8'h04);
    rd(8'h2C, 8'h40);
    rd(8'h3C, 8'h00);
    pg(4'h1);
    rd(8'h00, 8'h00);
    pg(4'h0);
    rd(8'h00, 8'h04);
    final_report;
  end
endmodule

// file: src/card_identity.v
// Functional notes
// - low byte: conform, id, fast, present, normal
// - presence bit always reads zero
// - separate status bit per interrupt source
// - normal irq asserted reads bit 0 one
// - fast irq asserted reads bit 2 one
// - incapable interrupt type reads zero
// - relocated status zeroes low byte bits
// - relocated mask zero for incapable type
// - extended identity forces simple id zero
// - conforming card returns bit 7 zero
// - seven further extended identity bytes supplied
// - extended bytes at fixed word offsets
// - flags: chunk dir, relocation, code width
// - reserved bits read as zero
// - loader located by directory entry
// - identity mapped at zero after reset
// - prefer extended identity over simple id
// - page zero selected on reset
// - code width encodings 8, 16, 32 bit
// - relocation flag means status elsewhere
`timescale 1ns/1ps
`include "card_identity_defs.vh"

module card_identity #(
  parameter       HAS_NORMAL_IRQ = 1,
  parameter       HAS_FAST_IRQ   = 1,
  parameter       USE_EXTENDED   = 1,
  parameter [3:0] SIMPLE_ID      = 4'h0,
  parameter       NON_CONFORM    = 0,
  parameter       CHUNK_DIR      = 1,
  parameter       RELOCATED      = 0,
  parameter [1:0] CODE_WIDTH     = `WIDTH_8BIT,
  parameter [15:0] PRODUCT_TYPE  = 16'h0000, // arbitrary value
  parameter [15:0] MAKER_CODE    = 16'h0000, // arbitrary value
  parameter [7:0] COUNTRY        = 8'h00,    // arbitrary value
  parameter [7:0] NORMAL_MASK    = 8'h01,
  parameter [7:0] FAST_MASK      = 8'h04,
  parameter [7:0] LOADER_OFFSET  = 8'h40,
  parameter [7:0] LOADER_SIZE    = 8'h40
) (
  // clock and reset
  input  wire       clk,
  input  wire       resetn,
  // card space read port
  input  wire       rd_strobe,
  input  wire [7:0] rd_addr,
  output reg  [7:0] rd_data,
  output reg        rd_valid,
  // page select from the card's driver
  input  wire       page_wr,
  input  wire [3:0] page_wdata,
  output reg  [3:0] page,
  // card interrupt lines, active low
  input  wire       card_normal_irq_n,
  input  wire       card_fast_irq_n
);

  // ----------------------------------------
  // derived identity fields
  // ----------------------------------------
  // an extended card must present a zero id, whatever the parameter says
  wire [3:0] simple_id_field = USE_EXTENDED ? 4'h0 : SIMPLE_ID;
  wire       reloc = (USE_EXTENDED != 0) && (RELOCATED != 0);
  wire       chunk_dir_follows = (USE_EXTENDED != 0) && (CHUNK_DIR != 0);
  // code width 3 is reserved, fall back to byte width
  wire [1:0] code_width = (CODE_WIDTH == 2'h3) ? `WIDTH_8BIT : CODE_WIDTH;

  // status follows the lines directly, reads never clear them
  wire normal_req = (HAS_NORMAL_IRQ != 0) && !card_normal_irq_n;
  wire fast_req   = (HAS_FAST_IRQ != 0) && !card_fast_irq_n;

  reg  [7:0] low_byte;
  reg  [7:0] flags_byte;
  reg  [7:0] next_rd_data;
  wire       page_zero = (page == `PAGE_RESET);

  always @* begin
    low_byte                      = 8'h00;
    low_byte[`BIT_NONCONFORM]     = (NON_CONFORM != 0);
    low_byte[`ID_MSB:`ID_LSB]     = simple_id_field;
    low_byte[`BIT_PRESENT]        = 1'b0;
    low_byte[`BIT_NORMAL_IRQ]     = normal_req & ~reloc;
    low_byte[`BIT_FAST_IRQ]       = fast_req & ~reloc;
    flags_byte                    = 8'h00;
    flags_byte[`BIT_CHUNK_DIR]    = chunk_dir_follows;
    flags_byte[`BIT_RELOCATED]    = reloc;
    flags_byte[`WIDTH_MSB:`WIDTH_LSB] = code_width;
  end

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  // identity sits in page zero only; other pages belong to paged code
  always @* begin
    next_rd_data = 8'h00;
    if (page_zero) begin
      case (rd_addr)
        `OFF_IDENTITY_LOW:      next_rd_data = low_byte;
        `OFF_IDENTITY_FLAGS:    next_rd_data = USE_EXTENDED ? flags_byte : 8'h00;
        `OFF_IDENTITY_RESERVED: next_rd_data = 8'h00;
        `OFF_PRODUCT_LOW:       next_rd_data = USE_EXTENDED ? PRODUCT_TYPE[7:0] : 8'h00;
        `OFF_PRODUCT_HIGH:      next_rd_data = USE_EXTENDED ? PRODUCT_TYPE[15:8] : 8'h00;
        `OFF_MAKER_LOW:         next_rd_data = USE_EXTENDED ? MAKER_CODE[7:0] : 8'h00;
        `OFF_MAKER_HIGH:        next_rd_data = USE_EXTENDED ? MAKER_CODE[15:8] : 8'h00;
        `OFF_COUNTRY:           next_rd_data = USE_EXTENDED ? COUNTRY : 8'h00;
        `OFF_STATUS_RELOC: begin
          // relocated status: normal in bit 0, fast in bit 2
          if (reloc)
            next_rd_data = {5'h00, fast_req, 1'b0, normal_req};
          else
            next_rd_data = 8'h00;
        end
        `OFF_STATUS_RELOC + 8'h04: begin
          // position masks, zero for a type the card cannot raise
          next_rd_data = (HAS_NORMAL_IRQ != 0) ? NORMAL_MASK : 8'h00;
        end
        `OFF_STATUS_RELOC + 8'h08: begin
          next_rd_data = (HAS_FAST_IRQ != 0) ? FAST_MASK : 8'h00;
        end
        `OFF_DIR_ENTRY + 8'h08: begin
          next_rd_data = chunk_dir_follows ? LOADER_OFFSET : 8'h00;
        end
        `OFF_DIR_ENTRY + 8'h0C: begin
          next_rd_data = chunk_dir_follows ? LOADER_SIZE : 8'h00;
        end
        default: next_rd_data = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // registered read data and page select
  // ----------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data  <= `READ_DATA_RESET;
      rd_valid <= 1'b0;
      page     <= `PAGE_RESET;
    end else begin
      rd_valid <= rd_strobe;
      if (rd_strobe)
        rd_data <= next_rd_data;
      if (page_wr)
        page <= page_wdata;
    end
  end

endmodule

// file: src/card_identity_defs.vh
`ifndef CARD_IDENTITY_DEFS_VH
`define CARD_IDENTITY_DEFS_VH

// ----------------------------------------
// card space word offsets (byte addresses)
// ----------------------------------------
`define OFF_IDENTITY_LOW      8'h00
`define OFF_IDENTITY_FLAGS    8'h04
`define OFF_IDENTITY_RESERVED 8'h08
`define OFF_PRODUCT_LOW       8'h0C
`define OFF_PRODUCT_HIGH      8'h10
`define OFF_MAKER_LOW         8'h14
`define OFF_MAKER_HIGH        8'h18
`define OFF_COUNTRY           8'h1C
`define OFF_STATUS_RELOC      8'h20
`define OFF_DIR_ENTRY         8'h24

// ----------------------------------------
// identity low byte fields
// ----------------------------------------
`define BIT_NORMAL_IRQ        0
`define BIT_PRESENT           1
`define BIT_FAST_IRQ          2
`define ID_LSB                3
`define ID_MSB                6
`define BIT_NONCONFORM        7

// ----------------------------------------
// flags byte fields
// ----------------------------------------
`define BIT_CHUNK_DIR         0
`define BIT_RELOCATED         1
`define WIDTH_LSB             2
`define WIDTH_MSB             3

// ----------------------------------------
// code width encodings
// ----------------------------------------
`define WIDTH_8BIT            2'h0
`define WIDTH_16BIT           2'h1
`define WIDTH_32BIT           2'h2

// ----------------------------------------
// reset values
// ----------------------------------------
`define PAGE_RESET            4'h0
`define READ_DATA_RESET       8'h00

`endif
